/* File: hw/regulator_control_byte_decoder.sv */
// control byte decoder for a five-regulator supply with two drain drivers
// assumes all serial pins and the power button are asynchronous inputs
`timescale 1ns/100ps
module regulator_control_byte_decoder (
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  input  wire logic                            two_wire_mode,
  input  wire logic                            cs_n,
  input  wire logic                            sclk,
  input  wire logic                            din,
  input  wire logic                            scl,
  input  wire logic                            sda_in,
  output logic                                 sda_out,
  output logic                                 sda_oe,
  input  wire logic                            address_select,
  input  wire logic                            power_button_n,
  output regulator_control_pkg::code_bank_t    active_code,
  output logic [4:0]                           regulator_enable,
  output logic                                 drain_driver_a_oe,
  output logic                                 drain_driver_b_oe,
  output logic                                 device_on
);
  import regulator_control_pkg::*;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // order: cs_n sclk din scl sda button address_select
  logic [6:0] pin_meta, pin_sync;
  logic       cs_sync, sclk_sync, din_sync, scl_sync, sda_sync;
  logic       button_sync, as_sync;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      // idle levels, so no false sclk edge follows the release of reset
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
    end else begin
      pin_meta <= {cs_n, sclk, din, scl, sda_in, power_button_n,
                   address_select};
      pin_sync <= pin_meta;
    end
  end

  always_comb begin
    {cs_sync, sclk_sync, din_sync, scl_sync, sda_sync, button_sync,
     as_sync} = pin_sync;
  end

  // ****************************************************************
  // three-wire receiver
  // ****************************************************************
  logic       prev_sclk, prev_cs;
  logic [7:0] spi_shift, next_spi_shift;
  logic [3:0] spi_count, next_spi_count;
  logic       sclk_rise, cs_rise, spi_valid, spi_active;

  always_comb begin
    spi_active     = device_on && !two_wire_mode;
    sclk_rise      = sclk_sync & ~prev_sclk;
    cs_rise        = cs_sync & ~prev_cs;
    next_spi_shift = spi_shift;
    next_spi_count = spi_count;
    // a frame counts only when eight bits arrived before chip select rose
    spi_valid = spi_active && cs_rise && (spi_count == COUNT_FULL);
    if (!spi_active || cs_sync) begin
      next_spi_count = COUNT_RESET;
    end else if (sclk_rise) begin
      next_spi_shift = {spi_shift[6:0], din_sync};
      if (spi_count != COUNT_FULL) begin
        next_spi_count = spi_count + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prev_sclk <= 1'b0;
      prev_cs   <= 1'b1;
      spi_shift <= 8'h00;
      spi_count <= COUNT_RESET;
    end else begin
      prev_sclk <= sclk_sync;
      prev_cs   <= cs_sync;
      spi_shift <= next_spi_shift;
      spi_count <= next_spi_count;
    end
  end

  // ****************************************************************
  // two-wire receiver
  // ****************************************************************
  logic          tw_valid;
  control_byte_s tw_byte;

  two_wire_byte_slave u_two_wire (
    .core_clk       (core_clk),
    .reset          (reset),
    .enable         (device_on && two_wire_mode),
    .scl            (scl_sync),
    .sda            (sda_sync),
    .address_select (as_sync),
    .sda_out        (sda_out),
    .sda_oe         (sda_oe),
    .byte_valid     (tw_valid),
    .byte_data      (tw_byte)
  );

  // ****************************************************************
  // command decode and settings
  // ****************************************************************
  code_bank_t    hold_code, next_hold_code;
  code_bank_t    next_active_code;
  logic [4:0]    next_regulator_enable;
  logic [1:0]    drivers, next_drivers;
  logic          next_device_on;
  logic          cmd_valid;
  control_byte_s cmd;

  // an unsigned code only ever rises with the setting it selects
  function automatic logic [2:0] code_slot(input logic [2:0] field);
    code_slot = field - CMD_CODE_FIRST;
  endfunction : code_slot

  always_comb begin
    // reset output state plays no part here: only device_on gates commands
    cmd_valid = device_on && (two_wire_mode ? tw_valid : spi_valid);
    cmd = two_wire_mode ? tw_byte : control_byte_s'(spi_shift);
    next_hold_code        = hold_code;
    next_active_code      = active_code;
    next_regulator_enable = regulator_enable;
    next_drivers          = drivers;
    next_device_on        = device_on;
    if (!device_on) begin
      // codes stay put so the restart comes back at the old voltage
      if (!button_sync) begin
        next_device_on        = 1'b1;
        next_regulator_enable = ENABLE_RESET;
      end
    end else if (cmd_valid) begin
      case (cmd.command_field)
        CMD_UPDATE: begin
          for (int i = 0; i < REG_COUNT; i++) begin
            if (cmd.data_field[i]) begin
              next_active_code[i] = hold_code[i];
            end
          end
        end
        CMD_DRIVER_ENABLE: begin
          next_drivers = cmd.data_field[1:0];
        end
        CMD_REG_ENABLE: begin
          next_regulator_enable = cmd.data_field;
          if (!cmd.data_field[0]) begin
            next_device_on        = 1'b0;
            next_regulator_enable = 5'h00;
            next_drivers          = DRIVER_RESET;
          end
        end
        default: begin
          // holding stage only; aux codes land even while disabled
          next_hold_code[code_slot(cmd.command_field)] =
            cmd.data_field;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_code         <= {REG_COUNT{CODE_RESET}};
      active_code       <= {REG_COUNT{CODE_RESET}};
      regulator_enable  <= ENABLE_RESET;
      drivers           <= DRIVER_RESET;
      drain_driver_a_oe <= 1'b0;
      drain_driver_b_oe <= 1'b0;
      device_on         <= 1'b1;
    end else begin
      hold_code         <= next_hold_code;
      active_code       <= next_active_code;
      regulator_enable  <= next_regulator_enable;
      drivers           <= next_drivers;
      drain_driver_a_oe <= next_drivers[0];
      drain_driver_b_oe <= next_drivers[1];
      device_on         <= next_device_on;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_reset_defaults: assert property (@(posedge core_clk)
    reset |=> active_code == {REG_COUNT{CODE_RESET}}
              && regulator_enable == ENABLE_RESET && device_on
              && !drain_driver_a_oe && !drain_driver_b_oe)
    else $error("power-up state wrong");

  chk_hold_not_live: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd.command_field >= CMD_CODE_FIRST
     && cmd.command_field <= CMD_CODE_LAST)
    |=> $stable(active_code)
        && hold_code[code_slot($past(cmd.command_field))]
           == $past(cmd.data_field))
    else $error("code write reached active stage");

  chk_update_copies: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd.command_field == CMD_UPDATE && cmd.data_field[0])
    |=> active_code[0] == $past(hold_code[0]))
    else $error("update did not copy holding code");

  chk_enable_apply: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd.command_field == CMD_REG_ENABLE
     && cmd.data_field[0])
    |=> regulator_enable == $past(cmd.data_field) && device_on)
    else $error("enable bits not applied");

  chk_shutdown: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd.command_field == CMD_REG_ENABLE
     && !cmd.data_field[0])
    |=> !device_on && regulator_enable == 5'h00
        && !drain_driver_a_oe && !drain_driver_b_oe)
    else $error("shutdown incomplete");

  chk_off_ignores: assert property (@(posedge core_clk) disable iff (reset)
    (!device_on && button_sync)
    |=> !device_on && $stable(hold_code) && $stable(active_code))
    else $error("serial traffic acted on while off");

  chk_short_frame: assert property (@(posedge core_clk) disable iff (reset)
    (!two_wire_mode && cs_rise && spi_count != COUNT_FULL)
    |=> $stable(hold_code) && $stable(active_code)
        && $stable(regulator_enable))
    else $error("short frame changed a setting");

  chk_codes_kept: assert property (@(posedge core_clk) disable iff (reset)
    $rose(device_on) |-> active_code == $past(active_code, 2)
                         && regulator_enable == ENABLE_RESET)
    else $error("codes lost across shutdown");

endmodule : regulator_control_byte_decoder

/* File: hw/regulator_control_pkg.sv */
// constants and carriers for the regulator control byte decoder
// assumes a 25 MHz core clock and serial pins that are asynchronous to it
package regulator_control_pkg;

  // ****************************************************************
  // control byte layout
  // ****************************************************************
  localparam int CMD_MSB  = 7;
  localparam int CMD_LSB  = 5;
  localparam int DATA_MSB = 4;
  localparam int DATA_LSB = 0;
  localparam int BYTE_BITS = 8;
  localparam int REG_COUNT = 5;

  typedef struct packed {
    logic [2:0] command_field;
    logic [4:0] data_field;
  } control_byte_s;

  typedef logic [REG_COUNT-1:0][4:0] code_bank_t;

  // ****************************************************************
  // commands
  // ****************************************************************
  localparam logic [2:0] CMD_UPDATE        = 3'h0;
  localparam logic [2:0] CMD_CODE_FIRST    = 3'h1;
  localparam logic [2:0] CMD_CODE_LAST     = 3'h5;
  localparam logic [2:0] CMD_DRIVER_ENABLE = 3'h6;
  localparam logic [2:0] CMD_REG_ENABLE    = 3'h7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [4:0] CODE_RESET    = 5'h1b;
  localparam logic [4:0] ENABLE_RESET  = 5'h01;
  localparam logic [1:0] DRIVER_RESET  = 2'h0;
  localparam logic [3:0] COUNT_RESET   = 4'h0;
  localparam logic [3:0] COUNT_FULL    = 4'h8;
  // idle pin levels: cs_n high, sclk and din low, scl, sda, button and
  // address select high
  localparam logic [6:0] PIN_IDLE      = 7'h4f;

  // ****************************************************************
  // bus addresses
  // ****************************************************************
  localparam logic [6:0] ADDR_SELECT_HIGH = 7'h3f;
  localparam logic [6:0] ADDR_SELECT_LOW  = 7'h4f;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CORE_CLK_HZ        = 25000000;
  localparam int SPI_MAX_RATE_HZ    = 2000000;
  localparam int SPI_MIN_BIT_CYCLES =
    (CORE_CLK_HZ + SPI_MAX_RATE_HZ - 1) / SPI_MAX_RATE_HZ;

endpackage : regulator_control_pkg

/* File: hw/two_wire_byte_slave.sv */
// write-only two-wire slave that delivers one control byte per data byte
// assumes scl and sda are already synchronised to core_clk
`timescale 1ns/100ps
module two_wire_byte_slave (
  input  wire logic                                  core_clk,
  input  wire logic                                  reset,
  input  wire logic                                  enable,
  input  wire logic                                  scl,
  input  wire logic                                  sda,
  input  wire logic                                  address_select,
  output logic                                       sda_out,
  output logic                                       sda_oe,
  output logic                                       byte_valid,
  output regulator_control_pkg::control_byte_s       byte_data
);
  import regulator_control_pkg::*;

  typedef enum logic [2:0] {
    IDLE, ADDR, ADDR_ACK, DATA, DATA_ACK, IGNORE
  } slave_state_e;

  slave_state_e  state, next_state;
  logic [7:0]    shift, next_shift;
  logic [3:0]    count, next_count;
  logic          next_sda_oe, next_byte_valid;
  control_byte_s next_byte_data;
  logic          prev_scl, prev_sda;
  logic          scl_rise, scl_fall, start_cond, stop_cond, addr_match;
  logic [6:0]    own_addr;

  // ****************************************************************
  // byte receiver
  // ****************************************************************
  always_comb begin
    scl_rise   = scl & ~prev_scl;
    scl_fall   = ~scl & prev_scl;
    start_cond = scl & prev_scl & prev_sda & ~sda;
    stop_cond  = scl & prev_scl & ~prev_sda & sda;
    own_addr   = address_select ? ADDR_SELECT_HIGH : ADDR_SELECT_LOW;
    addr_match = (shift[7:1] == own_addr) && !shift[0];
    next_state      = state;
    next_shift      = shift;
    next_count      = count;
    next_sda_oe     = sda_oe;
    next_byte_valid = 1'b0;
    next_byte_data  = byte_data;
    if (!enable) begin
      next_state  = IDLE;
      next_sda_oe = 1'b0;
    end else if (start_cond) begin
      next_state  = ADDR;
      next_count  = COUNT_RESET;
      next_sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_state  = IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ADDR, DATA: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda};
            next_count = count + 4'h1;
          end else if (scl_fall && count == COUNT_FULL) begin
            // foreign address or a read request: stay silent to the next start or stop
            if (state == DATA || addr_match) begin
              next_sda_oe = 1'b1;
              next_state  = (state == DATA) ? DATA_ACK : ADDR_ACK;
            end else begin
              next_state = IGNORE;
            end
          end
        end
        ADDR_ACK, DATA_ACK: begin
          if (scl_rise && state == DATA_ACK) begin
            next_byte_valid = 1'b1;
            next_byte_data  = control_byte_s'(shift);
          end else if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_count  = COUNT_RESET;
            next_state  = DATA;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state      <= IDLE;
      shift      <= 8'h00;
      count      <= COUNT_RESET;
      sda_oe     <= 1'b0;
      sda_out    <= 1'b0;
      byte_valid <= 1'b0;
      byte_data  <= '0;
      prev_scl   <= 1'b1;
      prev_sda   <= 1'b1;
    end else begin
      state      <= next_state;
      shift      <= next_shift;
      count      <= next_count;
      sda_oe     <= next_sda_oe;
      sda_out    <= 1'b0;
      byte_valid <= next_byte_valid;
      byte_data  <= next_byte_data;
      prev_scl   <= scl;
      prev_sda   <= sda;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_ack_own_addr: assert property (@(posedge core_clk) disable iff (reset)
    (enable && !start_cond && !stop_cond && state == ADDR && scl_fall
     && count == COUNT_FULL && addr_match) |=> sda_oe)
    else $error("own address not acknowledged");

  chk_foreign_silent: assert property (@(posedge core_clk) disable iff (reset)
    (enable && !start_cond && !stop_cond && state == ADDR && scl_fall
     && count == COUNT_FULL && !addr_match) |=> !sda_oe [*2])
    else $error("foreign address acknowledged");

  chk_byte_at_ninth: assert property (@(posedge core_clk) disable iff (reset)
    byte_valid |-> $past(state == DATA_ACK) && $past(scl_rise))
    else $error("byte delivered outside the ninth clock");

endmodule : two_wire_byte_slave

/* File: verification/serial_host_model.sv */
// behavioural serial host: three-wire mode 0 master and two-wire master
// assumes core_clk is the bench clock; pins change at its falling edge
`timescale 1ns/100ps
module serial_host_model (
  input  wire logic core_clk,
  input  wire logic sda_line,
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  output logic      scl,
  output logic      sda_low
);
  // ****************************************************************
  // timing
  // ****************************************************************
  // 13 clocks per three-wire bit keeps the rate under 2 MHz
  localparam int SPI_LOW  = 6;
  localparam int SPI_HIGH = 7;
  localparam int HALF     = 4;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge core_clk);
  endtask : gap

  // ****************************************************************
  // three-wire frames; nbits below 8 makes a cut-short frame
  // ****************************************************************
  task automatic spi_frame(input logic [7:0] b, input int nbits);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      din = b[7-i];
      gap(SPI_LOW);
      sclk = 1'b1;
      gap(SPI_HIGH);
      sclk = 1'b0;
    end
    gap(SPI_LOW);
    cs_n = 1'b1;
    // a deselected line must not keep showing the last bit
    din = ~din;
    gap(SPI_LOW);
  endtask : spi_frame

  // ****************************************************************
  // two-wire write-byte transactions
  // ****************************************************************
  // sda moves one clock after scl falls so it never races the clock
  task automatic i2c_bit(input logic b, output logic seen);
    gap(1);
    sda_low = ~b;
    gap(HALF - 1);
    scl = 1'b1;
    gap(HALF);
    seen = sda_line;
    scl = 1'b0;
  endtask : i2c_bit

  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(b[i], unused);
    end
    i2c_bit(1'b1, ack);
    ack = ~ack;
  endtask : i2c_byte

  task automatic i2c_write(input logic [6:0] addr, input logic [7:0] b,
                           output logic ack_a, output logic ack_d);
    sda_low = 1'b1;
    gap(HALF);
    scl = 1'b0;
    i2c_byte({addr, 1'b0}, ack_a);
    i2c_byte(b, ack_d);
    gap(1);
    sda_low = 1'b1;
    gap(HALF);
    scl = 1'b1;
    gap(HALF);
    sda_low = 1'b0;
    gap(HALF);
  endtask : i2c_write
endmodule : serial_host_model

/* File: verification/tb_regulator_control_byte_decoder.sv */
// self-checking bench for the regulator control byte decoder
// assumes the serial host model drives every serial pin
`timescale 1ns/100ps
module tb_regulator_control_byte_decoder;
  import regulator_control_pkg::*;
  logic       core_clk, reset, two_wire_mode, address_select;
  logic       power_button_n, cs_n, sclk, din, scl, sda_low, sda_line;
  logic       sda_out, sda_oe, drv_a, drv_b, device_on, ack_a, ack_d;
  logic       want_on;
  logic [4:0] regulator_enable, want_en;
  logic [1:0] want_drv;
  code_bank_t active_code, want_code, want_hold;
  int         fails = 0;
  int         checked = 0;
  int         cycles = 0;

  regulator_control_byte_decoder u_dut (
    .core_clk(core_clk), .reset(reset), .two_wire_mode(two_wire_mode),
    .cs_n(cs_n), .sclk(sclk), .din(din), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select(address_select),
    .power_button_n(power_button_n), .active_code(active_code),
    .regulator_enable(regulator_enable), .drain_driver_a_oe(drv_a),
    .drain_driver_b_oe(drv_b), .device_on(device_on));

  serial_host_model u_host (
    .core_clk(core_clk), .sda_line(sda_line), .cs_n(cs_n), .sclk(sclk),
    .din(din), .scl(scl), .sda_low(sda_low));

  // open-drain wire with pull-up
  assign sda_line = ~(sda_low | sda_oe);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  // ****************************************************************
  // checking and expectation model
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic check_state();
    check(32'(active_code), 32'(want_code));
    check({27'h0, regulator_enable}, {27'h0, want_en});
    check({30'h0, drv_b, drv_a}, {30'h0, want_drv});
    check({31'h0, device_on}, {31'h0, want_on});
  endtask : check_state

  task automatic init_model();
    want_code = {REG_COUNT{CODE_RESET}};
    want_hold = want_code;
    want_en = ENABLE_RESET;
    want_drv = DRIVER_RESET;
    want_on = 1'b1;
  endtask : init_model

  task automatic apply(input logic [7:0] b);
    control_byte_s c;
    c = control_byte_s'(b);
    if (!want_on) return;
    case (c.command_field)
      CMD_UPDATE: begin
        for (int i = 0; i < REG_COUNT; i++) begin
          if (c.data_field[i]) want_code[i] = want_hold[i];
        end
      end
      CMD_DRIVER_ENABLE: want_drv = c.data_field[1:0];
      CMD_REG_ENABLE: begin
        want_en = c.data_field;
        if (!c.data_field[0]) begin
          want_on = 1'b0;
          want_en = 5'h00;
          want_drv = 2'h0;
        end
      end
      default: want_hold[c.command_field - 3'h1] = c.data_field;
    endcase
  endtask : apply

  // one control byte over whichever port is selected, then compare
  task automatic cmd(input logic [7:0] b);
    logic [6:0] addr;
    addr = address_select ? ADDR_SELECT_HIGH : ADDR_SELECT_LOW;
    if (two_wire_mode) begin
      u_host.i2c_write(addr, b, ack_a, ack_d);
      check({31'h0, ack_a}, {31'h0, want_on});
      check({31'h0, ack_d}, {31'h0, want_on});
      check({31'h0, sda_out}, 32'h0);
    end else begin
      u_host.spi_frame(b, 8);
    end
    repeat (6) @(negedge core_clk);
    apply(b);
    check_state();
  endtask : cmd

  task automatic start(input logic two_wire);
    reset = 1'b1;
    two_wire_mode = two_wire;
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    init_model();
    repeat (3) @(negedge core_clk);
  endtask : start

  task automatic stop_test();
    $display("counts: checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    address_select = 1'b1;
    power_button_n = 1'b1;
    start(1'b0);
    check_state();
    check({31'h0, sda_oe}, 32'h0);
    $display("test reset done");
    for (int r = 0; r < REG_COUNT; r++) begin
      cmd({3'(r + 1), 5'(3 * r + 2)});
    end
    cmd(8'h02);
    cmd(8'h1f);
    u_host.spi_frame(8'h3f, 5);
    repeat (6) @(negedge core_clk);
    check_state();
    cmd(8'hc2);
    cmd(8'hc1);
    cmd(8'hf5);
    cmd(8'h3f);
    cmd(8'h01);
    $display("test three-wire commands done");
    cmd(8'he0);
    cmd(8'h25);
    cmd(8'h1f);
    power_button_n = 1'b0;
    repeat (6) @(negedge core_clk);
    power_button_n = 1'b1;
    repeat (6) @(negedge core_clk);
    want_on = 1'b1;
    want_en = ENABLE_RESET;
    check_state();
    cmd(8'h1f);
    $display("test shutdown done");
    start(1'b1);
    for (int s = 1; s >= 0; s--) begin
      address_select = s[0];
      repeat (6) @(negedge core_clk);
      cmd({3'h2, 5'(s + 4)});
      cmd(8'h1f);
      // the other device's address, carrying a shutdown byte
      u_host.i2c_write(s[0] ? ADDR_SELECT_LOW : ADDR_SELECT_HIGH, 8'he0,
                       ack_a, ack_d);
      repeat (6) @(negedge core_clk);
      check({31'h0, ack_a}, 32'h0);
      check({31'h0, ack_d}, 32'h0);
      check_state();
      cmd({7'h7d, s[0]});
    end
    $display("test two-wire done");
    stop_test();
  end
endmodule : tb_regulator_control_byte_decoder
